// ---- logic/serial_port_pkg.sv ----
// Constants, register map and carrier types of the serial port.
// What this block does
// [R01] Transmitter and receiver run independently from one shared baud generator.
// [R02] Infrared on: one narrow pulse per zero bit, none per one bit.
// [R03] Infrared pulse centred in its bit, width 1/32, 1/16 or 3/16.
// [R04] Transmit pulses timed from 16x and 32x ticks; receive decoder uses 16x.
// [R05] Infrared receive: pulse decodes as zero, no pulse as one, stretched.
// [R06] One setting inverts transmitted and expected received pulse polarity.
// [R07] Line format is NRZ normally, RZI when infrared is enabled.
// [R08] Frame is start, eight or nine data bits, stop: 10 or 11 bits.
// [R09] Characters carry plain data, data plus parity, or data plus address.
// [R10] A set address bit marks the frame as an address character.
// [R11] Ninth transmit bit is a held register bit, resent until rewritten.
// [R12] Baud generator is a 13-bit modulus counter, divisor 0 to 8191.
// [R13] Baud tick drives receiver at 16 samples per bit; /16 drives transmitter.
// [R14] Without infrared, bit rate equals clock over sixteen times divisor.
// [R15] Infrared only needs rates from 2.4 to 115.2 kbit/s.
// [R16] Baud generator stops while the divisor is zero.
// [R17] Writing the upper baud register alone leaves the divisor unchanged.
// [R18] Start bit is zero and stop bit is one.
// [R19] Data bits go least significant first; idle line is one.
package serial_port_pkg;

  localparam int DIV_W = 13;
  localparam int ADDR_W = 8;

  // Register byte addresses, one aligned word each.
  localparam logic [ADDR_W-1:0] OFF_BAUD_UPPER = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BAUD_LOWER = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CONTROL    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DATA_UPPER = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_DATA_LOWER = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h14;

  // Control register fields.
  localparam int CTL_NINE      = 0;
  localparam int CTL_IR_EN     = 1;
  localparam int CTL_IR_INV    = 2;
  localparam int CTL_PW_LO     = 3;
  localparam int CTL_TX_EN     = 5;
  localparam int CTL_RX_EN     = 6;
  localparam int CTL_ADDR_MODE = 7;

  // Data upper fields.
  localparam int DU_RX_NINTH = 7;
  localparam int DU_TX_NINTH = 6;

  // Reset values.
  localparam logic [DIV_W-1:0] DIVISOR_RESET = 13'h0000;
  localparam logic [7:0]       CONTROL_RESET = 8'h00;

  // Bit timing in 16x ticks and frame lengths.
  localparam logic [3:0] SUB_LAST     = 4'hF;
  localparam logic [3:0] SUB_SAMPLE   = 4'h7;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] DATA_BITS_8  = 4'h8;
  localparam logic [3:0] DATA_BITS_9  = 4'h9;

  // Infrared pulse windows in 32x phases of a bit, end exclusive; the receive stretch is in 16x ticks.
  localparam logic [4:0] PH_3_16_LO = 5'h0D;
  localparam logic [4:0] PH_3_16_HI = 5'h13;
  localparam logic [4:0] PH_1_16_LO = 5'h0F;
  localparam logic [4:0] PH_1_16_HI = 5'h11;
  localparam logic [4:0] PH_1_32_LO = 5'h10;
  localparam logic [4:0] PH_1_32_HI = 5'h11;
  localparam logic [4:0] IR_STRETCH = 5'h10;

  typedef enum logic [1:0] {PW_3_16, PW_1_16, PW_1_32} pulse_width_type;

  typedef struct packed {
    logic            enable;
    logic            invert;
    pulse_width_type width;
  } ir_cfg_type;

endpackage

// ---- logic/ir_codec.sv ----
// Infrared pulse encoder and decoder between the frame logic and the pins.
`timescale 1ns/1ps
module ir_codec (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  serial_port_pkg::ir_cfg_type     cfg,
  input  wire logic                       tick16,
  input  wire logic                       tick32,
  input  wire logic [3:0]                 tx_sub,
  input  wire logic                       tx_bit,
  input  wire logic                       rx_pin,
  output logic                            tx_pin,
  output logic                            rx_bit
);
  import serial_port_pkg::*;

  logic       half_q;
  logic [4:0] phase;
  logic       in_window;
  logic       rx_active;
  logic       seen_q;
  logic [4:0] stretch_q;

  // Half-step of the 16x tick, giving a 32x phase within the bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
    end else if (tick16) begin
      half_q <= 1'b0;
    end else if (tick32) begin
      half_q <= 1'b1; // [R04]
    end
  end

  assign phase = {tx_sub, half_q};

  // Window centred on phase 16, the middle of the bit cell.
  always_comb begin
    unique case (cfg.width)
      PW_1_16: in_window = phase >= PH_1_16_LO && phase < PH_1_16_HI; // [R03]
      PW_1_32: in_window = phase >= PH_1_32_LO && phase < PH_1_32_HI; // [R03]
      default: in_window = phase >= PH_3_16_LO && phase < PH_3_16_HI; // [R03]
    endcase
  end

  // Zero bits become a pulse, ones stay dark; NRZ passes the bit through.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin <= 1'b1;
    end else if (cfg.enable) begin
      tx_pin <= (!tx_bit && in_window) ^ cfg.invert; // [R02] [R06] [R07]
    end else begin
      tx_pin <= tx_bit; // [R07]
    end
  end

  assign rx_active = rx_pin ^ cfg.invert; // [R06]

  // A pulse shorter than a tick is caught here so the next tick sees it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else if (tick16) begin
      seen_q <= 1'b0;
    end else if (rx_active) begin
      seen_q <= 1'b1;
    end
  end

  // Each pulse is stretched to a full bit of 16x ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_q <= 5'h00;
    end else if (tick16) begin
      if (seen_q || rx_active) begin
        stretch_q <= IR_STRETCH; // [R05] [R04]
      end else if (stretch_q != 5'h00) begin
        stretch_q <= stretch_q - 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit <= 1'b1;
    end else begin
      rx_bit <= cfg.enable ? (stretch_q == 5'h00) : rx_pin; // [R05]
    end
  end

  chk_ir_one_dark: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
    cfg.enable && tx_bit |=> tx_pin == $past(cfg.invert))
    else $error("Infrared line pulsed for a one bit.");

  chk_nrz_passthrough: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
    !cfg.enable |=> tx_pin == $past(tx_bit))
    else $error("NRZ line does not follow the transmit bit.");

  chk_ir_stretch_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
    cfg.enable && tick16 && rx_active ##1 cfg.enable |=> !rx_bit)
    else $error("Received pulse not decoded as zero.");

  cov_ir_pulse: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.enable && !tx_bit && in_window);

endmodule // ir_codec

// ---- logic/serial_port.sv ----
// Serial port with baud generator, framing, infrared codec and APB registers.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module serial_port (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [serial_port_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                         pwdata,
  output logic [31:0]                              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                rx_pin,
  output logic                                     tx_pin
);
  import serial_port_pkg::*;

  typedef enum {TX_IDLE, TX_SHIFT} tx_state_type;
  typedef enum {RX_IDLE, RX_RECV} rx_state_type;

  logic [DIV_W-1:0] baud_divisor_q;
  logic [4:0]       baud_upper_q;
  logic [DIV_W-1:0] baud_cnt_q;
  logic [7:0]       control_q;
  logic             tx_ninth_bit_q;
  logic [7:0]       tx_buf_q;
  logic             tx_full_q;
  tx_state_type     tx_state_q;
  logic [10:0]      tx_shift_q;
  logic [3:0]       tx_left_q;
  logic [3:0]       tx_sub_q;
  rx_state_type     rx_state_q;
  logic [3:0]       rx_sub_q;
  logic [3:0]       rx_idx_q;
  logic [8:0]       rx_shift_q;
  logic [8:0]       rx_data_q;
  logic             rx_full_q;
  logic             overrun_q;
  logic             frame_err_q;
  logic             rx_address_q;
  logic             clk_baud_x16;
  logic             clk_baud_x32;
  logic             access;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic             tx_load;
  logic             tx_bit;
  logic             rx_bit;
  logic             rx_done;
  logic             nine;
  logic [3:0]       data_bits;
  ir_cfg_type       ir_cfg;
  logic [31:0]      read_value;

  assign nine      = control_q[CTL_NINE];
  assign data_bits = nine ? DATA_BITS_9 : DATA_BITS_8; // [R08]
  assign ir_cfg    = '{enable: control_q[CTL_IR_EN],
                       invert: control_q[CTL_IR_INV],
                       width:  pulse_width_type'(control_q[CTL_PW_LO+:2])};

  // APB decode; every access finishes without wait states.
  assign access  = psel && penable;
  assign addr_ok = paddr == OFF_BAUD_UPPER || paddr == OFF_BAUD_LOWER ||
                   paddr == OFF_CONTROL || paddr == OFF_DATA_UPPER ||
                   paddr == OFF_DATA_LOWER || paddr == OFF_STATUS;
  assign wr_en   = access && pwrite && addr_ok;
  assign rd_en   = access && !pwrite && addr_ok;
  assign pready  = access;
  assign pslverr = access && !addr_ok;

  // The divisor moves only on a lower write; an upper write is just staged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_upper_q   <= 5'h00;
      baud_divisor_q <= DIVISOR_RESET;
    end else if (wr_en && paddr == OFF_BAUD_UPPER) begin
      baud_upper_q <= pwdata[4:0]; // [R17]
    end else if (wr_en && paddr == OFF_BAUD_LOWER) begin
      baud_divisor_q <= {baud_upper_q, pwdata[7:0]}; // [R17] [R12]
    end
  end

  // Control and the held ninth transmit bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q      <= CONTROL_RESET;
      tx_ninth_bit_q <= 1'b0;
    end else if (wr_en && paddr == OFF_CONTROL) begin
      control_q <= pwdata[7:0];
    end else if (wr_en && paddr == OFF_DATA_UPPER) begin
      tx_ninth_bit_q <= pwdata[DU_TX_NINTH]; // [R11]
    end
  end

  // Modulus counter; a zero divisor holds it still with no ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_q <= '0;
    end else if (baud_divisor_q == '0 || clk_baud_x16) begin
      baud_cnt_q <= '0; // [R16]
    end else begin
      baud_cnt_q <= baud_cnt_q + 13'h0001; // [R12]
    end
  end

  // One 16x tick per divisor clocks, so the bit rate is clock/(16*div).
  assign clk_baud_x16 = baud_divisor_q != '0 &&
                        baud_cnt_q == baud_divisor_q - 13'h0001; // [R14] [R13]
  // The mid-count tick needs a divisor of at least two, which the infrared range has.
  // It fires half a divisor before the 16x tick, so each half-step is real.
  assign clk_baud_x32 = clk_baud_x16 || (baud_divisor_q > 13'h0001 &&
                        baud_cnt_q == ((baud_divisor_q >> 1) -
                                       13'h0001)); // [R15] [R04]

  // Transmit buffer; a write in the load cycle keeps the buffer full.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_q  <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (wr_en && paddr == OFF_DATA_LOWER) begin
      tx_buf_q  <= pwdata[7:0];
      tx_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_full_q <= 1'b0;
    end
  end

  assign tx_load = tx_state_q == TX_IDLE && tx_full_q &&
                   control_q[CTL_TX_EN] && clk_baud_x16;

  // Transmit shifter runs on the 16x tick, one bit per sixteen ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 11'h7FF;
      tx_left_q  <= 4'h0;
      tx_sub_q   <= 4'h0;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          if (tx_load) begin
            // Stop one, ninth or filler, data LSB first, start zero.
            tx_shift_q <= {1'b1, nine ? tx_ninth_bit_q : 1'b1,
                           tx_buf_q, 1'b0}; // [R18] [R19] [R09] [R11]
            tx_left_q  <= nine ? FRAME_BITS_9 : FRAME_BITS_8; // [R08]
            tx_sub_q   <= 4'h0;
            tx_state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (clk_baud_x16) begin
            tx_sub_q <= tx_sub_q + 4'h1; // [R13]
            if (tx_sub_q == SUB_LAST) begin
              tx_shift_q <= {1'b1, tx_shift_q[10:1]};
              tx_left_q  <= tx_left_q - 4'h1;
              if (tx_left_q == 4'h1) begin
                tx_state_q <= TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // Idle line is a one; during a frame the shifter's low bit goes out.
  assign tx_bit = tx_state_q == TX_SHIFT ? tx_shift_q[0] : 1'b1; // [R19]

  // Receiver is independent of the transmitter and shares only the ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= RX_IDLE;
      rx_sub_q   <= 4'h0;
      rx_idx_q   <= 4'h0;
      rx_shift_q <= 9'h000;
    end else if (clk_baud_x16) begin // [R01]
      unique case (rx_state_q)
        RX_IDLE: begin
          if (control_q[CTL_RX_EN] && !rx_bit) begin
            rx_state_q <= RX_RECV;
            rx_sub_q   <= 4'h0;
            rx_idx_q   <= 4'h0;
            rx_shift_q <= 9'h000;
          end
        end
        RX_RECV: begin
          rx_sub_q <= rx_sub_q + 4'h1; // [R13]
          if (rx_sub_q == SUB_SAMPLE) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && rx_bit) begin
              rx_state_q <= RX_IDLE; // A glitch, not a start bit.
            end else if (rx_idx_q != 4'h0 && rx_idx_q <= data_bits) begin
              rx_shift_q[rx_idx_q - 4'h1] <= rx_bit; // [R19]
            end else if (rx_idx_q > data_bits) begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign rx_done = clk_baud_x16 && rx_state_q == RX_RECV &&
                   rx_sub_q == SUB_SAMPLE && rx_idx_q > data_bits;

  // Received character; a new frame in the read cycle keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q    <= 9'h000;
      rx_full_q    <= 1'b0;
      overrun_q    <= 1'b0;
      frame_err_q  <= 1'b0;
      rx_address_q <= 1'b0;
    end else if (rx_done && rx_full_q) begin
      overrun_q <= 1'b1; // Old character kept, new one is lost.
    end else if (rx_done) begin
      rx_data_q    <= rx_shift_q;
      rx_full_q    <= 1'b1;
      frame_err_q  <= !rx_bit; // [R18]
      // The top character bit marks an address frame in address mode.
      rx_address_q <= control_q[CTL_ADDR_MODE] &&
                      (nine ? rx_shift_q[8] : rx_shift_q[7]); // [R10] [R09]
    end else if (rd_en && paddr == OFF_DATA_LOWER) begin
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
    end
  end

  ir_codec u_ir_codec (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (ir_cfg),
    .tick16  (clk_baud_x16),
    .tick32  (clk_baud_x32),
    .tx_sub  (tx_sub_q),
    .tx_bit  (tx_bit),
    .rx_pin  (rx_pin),
    .tx_pin  (tx_pin),
    .rx_bit  (rx_bit)
  );

  // Read mux, sampled in the setup phase so prdata is a flop in access.
  always_comb begin
    read_value = 32'h0000_0000;
    unique case (paddr)
      OFF_BAUD_UPPER: read_value[4:0] = baud_divisor_q[12:8];
      OFF_BAUD_LOWER: read_value[7:0] = baud_divisor_q[7:0];
      OFF_CONTROL:    read_value[7:0] = control_q;
      OFF_DATA_UPPER: begin
        read_value[DU_RX_NINTH] = rx_data_q[8];
        read_value[DU_TX_NINTH] = tx_ninth_bit_q;
      end
      OFF_DATA_LOWER: read_value[7:0] = rx_data_q[7:0];
      OFF_STATUS:     read_value[6:0] = {rx_address_q, frame_err_q,
                                         overrun_q,
                                         rx_state_q == RX_RECV,
                                         tx_state_q == TX_SHIFT,
                                         rx_full_q, !tx_full_q};
      default:        read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= read_value;
    end
  end

  chk_baud_stopped: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    baud_divisor_q == '0 |-> !clk_baud_x16 && baud_cnt_q == '0)
    else $error("Baud tick while divisor is zero.");

  chk_upper_alone: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
    wr_en && paddr == OFF_BAUD_UPPER |=> $stable(baud_divisor_q))
    else $error("Upper baud write changed the divisor.");

  chk_div_two_period: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    clk_baud_x16 && baud_divisor_q == 13'h0002 && !wr_en
    |=> !clk_baud_x16 ##1 clk_baud_x16)
    else $error("Tick spacing differs from the divisor.");

  chk_start_bit: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    tx_load |=> tx_bit == 1'b0 && tx_state_q == TX_SHIFT)
    else $error("Frame does not open with a zero start bit.");

  chk_stop_bit: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    tx_state_q == TX_SHIFT && tx_left_q == 4'h1 |-> tx_bit)
    else $error("Stop bit is not a one.");

  chk_frame_length: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
    tx_load |=> tx_left_q == ($past(nine) ? FRAME_BITS_9 : FRAME_BITS_8))
    else $error("Frame length is not 10 or 11 bits.");

  chk_ninth_held: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    tx_load ##1 tx_state_q == TX_SHIFT |-> $stable(tx_ninth_bit_q))
    else $error("Held ninth bit changed on transmission.");

  chk_rx_delivered: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
    rx_done && !rx_full_q |=> rx_full_q && rx_data_q == $past(rx_shift_q))
    else $error("Received character not delivered.");

  cov_tx_frame: cover property (@(posedge pclk) disable iff (!presetn)
    tx_load && nine);

  cov_rx_frame: cover property (@(posedge pclk) disable iff (!presetn)
    rx_done && ir_cfg.enable);

  cov_rx_overrun: cover property (@(posedge pclk) disable iff (!presetn)
    rx_done && rx_full_q);

endmodule // serial_port

// ---- dv/remote_serial.sv ----
// Remote serial peer: sends frames on rx_pin and decodes frames on tx_pin.
`timescale 1ns/1ps
module remote_serial (
  input  wire logic pclk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // Park the line at its idle level so a mode change raises no false start.
  task automatic settle(input logic ir, input logic inv, input int bt);
    @(posedge pclk);
    line_out <= ir ? inv : 1'b1;
    repeat (bt) @(posedge pclk);
  endtask

  // One frame, LSB first; infrared zeros become a centred 3/16 pulse.
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic ir, input logic inv, input int bt);
    logic [10:0] fr;
    fr = {1'b1, data, 1'b0};
    for (int k = 0; k < nbits; k++) begin
      for (int c = 0; c < bt; c++) begin
        @(posedge pclk);
        if (!ir) line_out <= fr[k];
        else line_out <= (!fr[k] && c >= bt * 13 / 32 &&
                          c < bt * 19 / 32) ? !inv : inv;
      end
    end
    @(posedge pclk);
    line_out <= ir ? inv : 1'b1;
  endtask

  // Counts active samples in bit windows that start at the first edge.
  // Sampling on the falling edge keeps clear of the registered pin update.
  task automatic recv(input int nbits, input logic ir, input logic act,
                      input int bt, output logic [10:0] bits,
                      output int width, output logic ok);
    int cnt;
    bits = '1;
    width = 0;
    ok = 1'b0;
    for (int n = 0; n < 4000 && !ok; n++) begin
      @(negedge pclk);
      ok = (line_in === act);
    end
    for (int k = 0; k < nbits && ok; k++) begin
      cnt = 0;
      for (int c = 0; c < bt; c++) begin
        if (line_in === act) cnt++;
        @(negedge pclk);
      end
      bits[k] = ir ? (cnt == 0) : (cnt <= bt / 2);
      if (k == 0) width = cnt;
    end
  endtask
endmodule // remote_serial

// ---- dv/async_serial_ir_baud_framing_bench.sv ----
// Self-checking bench for the serial port over APB with a remote peer.
`timescale 1ns/1ps
module async_serial_ir_baud_framing_bench import serial_port_pkg::*;;
  localparam int BT = 32;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              rx_pin;
  logic              tx_pin;
  logic [31:0]       d;
  logic              e;
  int                fail_count = 0;
  int                checks = 0;
  int                z;
  int                pw [3] = '{6, 2, 1};

  serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin(tx_pin));
  remote_serial peer (.pclk(pclk), .line_in(tx_pin), .line_out(rx_pin));

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  task automatic close_out;
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, v, r, x);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0, r, x);
    check({r[31:1] & m[31:1], (r[0] & m[0]) | x}, exp);
  endtask

  // Starts a frame with one write and decodes it at the pin.
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic [7:0] v,
                      input int nbits, input logic ninth, input logic ir,
                      input logic act, input int ew);
    logic [10:0] bits;
    int          w;
    logic        ok;
    fork
      peer.recv(nbits, ir, act, BT, bits, w, ok);
      wr(a, (a == OFF_DATA_LOWER) ? {24'h0, v} : 32'h2);
    join
    check(ok, 1'b1);
    if (!ok) close_out();
    check(bits, {1'b1, ninth, v, 1'b0});
    check(w, ew);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFF_CONTROL, 32'hFE, 32'h0);
    rd_chk(OFF_BAUD_UPPER, 32'h3E, 32'h0);
    apb(1'b0, 8'h40, 32'h0, d, e);
    check({d[30:0], e}, 32'h1);
    // A loaded character must wait while the divisor is zero.
    wr(OFF_CONTROL, 32'h20);
    wr(OFF_DATA_LOWER, 32'h55);
    z = 0;
    repeat (300) @(negedge pclk) z += (tx_pin !== 1'b1);
    check(z, 0);
    wr(OFF_BAUD_UPPER, 32'h1F);
    rd_chk(OFF_BAUD_UPPER, 32'h3E, 32'h0);
    wr(OFF_BAUD_UPPER, 32'h0);
    xfer(OFF_BAUD_LOWER, 8'h55, 10, 1'b1, 1'b0, 1'b0, BT);
    rd_chk(OFF_BAUD_LOWER, 32'hFE, 32'h2);
    // Held ninth bit goes out on two frames written without a rewrite.
    wr(OFF_CONTROL, 32'h21);
    wr(OFF_DATA_UPPER, 32'h40);
    xfer(OFF_DATA_LOWER, 8'h3C, 11, 1'b1, 1'b0, 1'b0, BT);
    xfer(OFF_DATA_LOWER, 8'hC3, 11, 1'b1, 1'b0, 1'b0, BT);
    rd_chk(OFF_DATA_UPPER, 32'h40, 32'h40);
    // Both directions at once, with an address character arriving.
    wr(OFF_CONTROL, 32'hE0);
    fork
      peer.send(9'h196, 10, 1'b0, 1'b0, BT);
      xfer(OFF_DATA_LOWER, 8'h0F, 10, 1'b1, 1'b0, 1'b0, BT);
    join
    rd_chk(OFF_STATUS, 32'h42, 32'h42);
    rd_chk(OFF_DATA_LOWER, 32'hFE, 32'h96);
    rd_chk(OFF_STATUS, 32'h02, 32'h0);
    // Every pulse width with both polarities when sending; the peer always sends 3/16 pulses to the receiver.
    for (int inv = 0; inv < 2; inv++) begin
      for (int w = 0; w < 3; w++) begin
        wr(OFF_CONTROL, 32'h22 | (inv << 2) | (w << 3));
        peer.settle(1'b1, inv[0], 2 * BT);
        wr(OFF_CONTROL, 32'h62 | (inv << 2) | (w << 3));
        fork
          peer.send(9'h1A6, 10, 1'b1, inv[0], BT);
          xfer(OFF_DATA_LOWER, 8'hA6, 10, 1'b1, 1'b1, !inv[0],
               pw[w]);
        join
        rd_chk(OFF_DATA_LOWER, 32'hFE, 32'hA6);
      end
    end
    close_out();
  end
endmodule // async_serial_ir_baud_framing_bench
